// ==== pm_ctrl_pkg.sv ====
package pm_ctrl_pkg;

  // Port count and the port whose state governs the whole device
  localparam int NUM_PORTS_DEF = 16;
  localparam int UPSTREAM_PORT = 0;

  // Power-state field codes and reset values
  localparam logic [1:0] PS_CODE_D0 = 2'h0;
  localparam logic [1:0] PS_CODE_D3HOT = 2'h3;
  localparam logic [1:0] PS_FIELD_RST = 2'h0;
  localparam logic CONTEXT_KEPT_RST = 1'h1;

  // Device power states, Gray coded along the usual path
  typedef enum logic [1:0] {
    PM_D0_UNINIT = 2'h0,
    PM_D0_ACTIVE = 2'h1,
    PM_D3_HOT = 2'h3,
    PM_D3_COLD = 2'h2
  } pm_state_type;

  // Kind of a received transaction
  typedef enum logic [2:0] {
    TLP_CFG0 = 3'h0,
    TLP_CFG1 = 3'h1,
    TLP_MEM_IO = 3'h2,
    TLP_MSG = 3'h3,
    TLP_CPL = 3'h4
  } tlp_kind_type;

  // Verdict on a received transaction
  typedef enum logic [2:0] {
    DEC_NONE = 3'h0,
    DEC_ROUTE = 3'h1,
    DEC_ACCEPT = 3'h2,
    DEC_UR = 3'h3,
    DEC_UC = 3'h4
  } tlp_decision_type;

  // Fence sequence states
  typedef enum logic [1:0] {
    FENCE_IDLE = 2'h0,
    FENCE_WAIT = 2'h1,
    FENCE_DONE = 2'h3
  } fence_state_type;

  typedef struct packed {
    logic valid;
    logic from_secondary;
    logic to_bridge;
    tlp_kind_type kind;
  } tlp_info_type;

  typedef struct packed {
    logic wr;
    logic [1:0] wdata;
  } pm_control_status_reg_write_type;

  typedef struct packed {
    logic valid;
    tlp_decision_type decision;
  } tlp_verdict_type;

endpackage : pm_ctrl_pkg

// ==== bridge_pm_fsm.sv ====
`timescale 1ns/1ns
module bridge_pm_fsm (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Software and supply events
  input pm_ctrl_pkg::pm_control_status_reg_write_type pm_control_status_reg_wr,
  input wire logic configured,
  input wire logic power_removed,
  // Power state
  output pm_ctrl_pkg::pm_state_type state,
  output logic [1:0] power_state_field,
  output logic context_kept_flag
);
  import pm_ctrl_pkg::*;

  pm_state_type state_reg;
  pm_state_type state_next;
  logic [1:0] field_reg;
  logic context_reg;

  // Next state; D1 and D2 codes fall through as no change
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PM_D0_UNINIT:
        if (configured) state_next = PM_D0_ACTIVE;
      PM_D0_ACTIVE:
        if (pm_control_status_reg_wr.wr && pm_control_status_reg_wr.wdata == PS_CODE_D3HOT) state_next = PM_D3_HOT;
      PM_D3_HOT:
        if (power_removed) state_next = PM_D3_COLD;
        else if (pm_control_status_reg_wr.wr && pm_control_status_reg_wr.wdata == PS_CODE_D0) state_next = PM_D0_UNINIT;
      default:
        state_next = PM_D3_COLD; // Only a fundamental reset leaves D3cold
    endcase
  end

  // State register; fundamental reset returns to D0 uninitialized
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn) state_reg <= PM_D0_UNINIT;
    else state_reg <= state_next;

  // Readable power-state field follows the state
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn) field_reg <= PS_FIELD_RST;
    else field_reg <= (state_next == PM_D3_HOT || state_next == PM_D3_COLD) ? PS_CODE_D3HOT : PS_CODE_D0;

  // Context is never lost on leaving D3hot, so the flag never clears
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn) context_reg <= CONTEXT_KEPT_RST;
    else context_reg <= context_reg;

  assign state = state_reg;
  assign power_state_field = field_reg;
  assign context_kept_flag = context_reg;

  property p_enter_d3hot;
    @(posedge clk_sys) disable iff (!rstn)
    state_reg == PM_D0_ACTIVE && pm_control_status_reg_wr.wr && pm_control_status_reg_wr.wdata == PS_CODE_D3HOT
      |=> state_reg == PM_D3_HOT ##1 field_reg == PS_CODE_D3HOT || state_reg != PM_D3_HOT;
  endproperty
  a_enter_d3hot: assert property (p_enter_d3hot) else $error("D3hot write not taken");

  property p_leave_d3hot;
    @(posedge clk_sys) disable iff (!rstn)
    state_reg == PM_D3_HOT && !power_removed && pm_control_status_reg_wr.wr && pm_control_status_reg_wr.wdata == PS_CODE_D0
      |=> state_reg == PM_D0_UNINIT && context_reg;
  endproperty
  a_leave_d3hot: assert property (p_leave_d3hot) else $error("D0 write did not leave D3hot");

  property p_bad_code;
    @(posedge clk_sys) disable iff (!rstn)
    pm_control_status_reg_wr.wr && (pm_control_status_reg_wr.wdata == 2'h1 || pm_control_status_reg_wr.wdata == 2'h2) && !configured && !power_removed
      |=> $stable(state_reg);
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("Unsupported code changed state");

  property p_context_kept;
    @(posedge clk_sys) disable iff (!rstn)
    $past(state_reg) == PM_D3_HOT && state_reg == PM_D0_UNINIT |-> context_reg;
  endproperty
  a_context_kept: assert property (p_context_kept) else $error("Context flag lost");

endmodule : bridge_pm_fsm

// ==== pme_fence.sv ====
`timescale 1ns/1ns
module pme_fence #(
  parameter int NUM_PORTS = pm_ctrl_pkg::NUM_PORTS_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Turn-off request and acknowledges
  input wire logic turn_off_rx,
  input wire logic [NUM_PORTS-1:0] link_active,
  input wire logic [NUM_PORTS-1:0] ack_rx,
  input wire logic resume,
  // Forwarding and upstream acknowledge
  output logic [NUM_PORTS-1:0] turn_off_fwd,
  output logic ack_tx,
  output logic done
);
  import pm_ctrl_pkg::*;

  // Bit of the upstream port, which is never a forwarding target
  localparam logic [NUM_PORTS-1:0] UP_MASK = NUM_PORTS'(1) << UPSTREAM_PORT;

  fence_state_type state_reg;
  logic [NUM_PORTS-1:0] pending_reg;
  logic [NUM_PORTS-1:0] fwd_reg;
  logic ack_reg;
  logic [NUM_PORTS-1:0] pending_next;

  assign pending_next = pending_reg & ~ack_rx;

  // Broadcast, then collect one acknowledge per forwarded port
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      state_reg <= FENCE_IDLE;
      pending_reg <= '0;
      fwd_reg <= '0;
      ack_reg <= 1'b0;
    end
    else
    begin
      fwd_reg <= '0;
      ack_reg <= 1'b0;
      case (state_reg)
        FENCE_IDLE:
          if (turn_off_rx)
          begin
            fwd_reg <= link_active & ~UP_MASK;
            pending_reg <= link_active & ~UP_MASK;
            state_reg <= FENCE_WAIT;
          end
        FENCE_WAIT:
        begin
          pending_reg <= pending_next;
          if (pending_next == '0)
          begin
            ack_reg <= 1'b1;
            state_reg <= FENCE_DONE;
          end
        end
        default:
          if (resume) state_reg <= FENCE_IDLE;
      endcase
    end

  assign turn_off_fwd = fwd_reg;
  assign ack_tx = ack_reg;
  assign done = (state_reg == FENCE_DONE);

  property p_ack_after_all;
    @(posedge clk_sys) disable iff (!rstn)
    ack_reg |-> $past(pending_next) == '0 && $past(state_reg) == FENCE_WAIT;
  endproperty
  a_ack_after_all: assert property (p_ack_after_all) else $error("Ack sent with ports pending");

endmodule : pme_fence

// ==== pcie_bridge_power_state_control.sv ====
`timescale 1ns/1ns
// Behaviour
// - A downstream bridge's power state affects only its own port.
// - A bridge in D3hot lets its link enter L1.
// - Upstream port low power plus all turn-off acks puts whole device low.
// - Four states: D0 uninitialized, D0 active, D3hot, D3cold.
// - Fundamental reset gives D0 uninitialized; configuration moves it to D0 active.
// - D0 active plus D3hot code write moves to D3hot.
// - D3hot plus D0 code write returns to D0 uninitialized.
// - Leaving D3hot resets no logic and reloads no register.
// - Context-kept flag resets to show context survives D3hot.
// - In D3hot, type 0 configuration reads and writes are completed.
// - In D3hot, messages aimed at the bridge are accepted.
// - In D3hot, other primary-side requests are unsupported requests.
// - In D3hot, errors caused by a received TLP are reported as usual.
// - In D3hot, errors from other causes are dropped silently.
// - In D3hot, completions aimed at the bridge are unexpected completions.
// - In D3hot, passing completions are routed as in D0.
// - In D3hot, requests on the secondary side are unsupported requests.
// - Turn-off is forwarded to active downstream ports; ack waits for all.
module pcie_bridge_power_state_control #(
  parameter int NUM_PORTS = pm_ctrl_pkg::NUM_PORTS_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Configuration events, one entry per port, and a power-removal input shared by all ports
  input pm_ctrl_pkg::pm_control_status_reg_write_type pm_control_status_reg_wr [NUM_PORTS],
  input wire logic [NUM_PORTS-1:0] configured,
  input wire logic power_removed,
  // Received traffic and error events per port
  input pm_ctrl_pkg::tlp_info_type tlp_in [NUM_PORTS],
  input wire logic [NUM_PORTS-1:0] err_tlp_evt,
  input wire logic [NUM_PORTS-1:0] err_other_evt,
  // Power management fence inputs
  input wire logic pme_turn_off_rx,
  input wire logic [NUM_PORTS-1:0] link_active,
  input wire logic [NUM_PORTS-1:0] pme_to_ack_rx,
  // Port power status
  output pm_ctrl_pkg::pm_state_type port_state [NUM_PORTS],
  output logic [1:0] power_state_field [NUM_PORTS],
  output logic [NUM_PORTS-1:0] context_kept_flag,
  output logic [NUM_PORTS-1:0] l1_allowed,
  // Traffic verdicts and error messages
  output pm_ctrl_pkg::tlp_verdict_type verdict [NUM_PORTS],
  output logic [NUM_PORTS-1:0] err_msg_send,
  output logic [NUM_PORTS-1:0] err_msg_drop,
  // Fence and device state
  output logic [NUM_PORTS-1:0] pme_turn_off_fwd,
  output logic pme_to_ack_tx,
  output logic l2l3_ready,
  output logic device_low_power
);
  import pm_ctrl_pkg::*;

  logic fence_done;
  logic upstream_low_reg;
  logic device_low_reg;
  logic l2l3_reg;

  // Verdict for one transaction given the bridge's power state
  function automatic tlp_decision_type classify(input pm_state_type st, input tlp_info_type t);
    tlp_decision_type d;
    d = DEC_ROUTE;
    if (st == PM_D3_HOT)
    begin
      if (t.kind == TLP_CPL)
        d = t.to_bridge ? DEC_UC : DEC_ROUTE;
      else if (t.from_secondary)
        d = DEC_UR;
      else if (t.kind == TLP_CFG0)
        d = DEC_ACCEPT;
      else if (t.kind == TLP_MSG && t.to_bridge)
        d = DEC_ACCEPT;
      else
        d = DEC_UR;
    end
    else
    begin
      // D0 handling: the bridge consumes what targets it, forwards the rest
      if (t.kind == TLP_CFG0)
        d = DEC_ACCEPT;
      else if ((t.kind == TLP_MSG || t.kind == TLP_CPL) && t.to_bridge)
        d = DEC_ACCEPT;
      else
        d = DEC_ROUTE;
    end
    return d;
  endfunction : classify

  // Each port owns a private state machine, so no port sees another's state
  for (genvar g = 0; g < NUM_PORTS; g++)
  begin : g_port
    tlp_verdict_type verdict_reg;
    logic err_send_reg;
    logic err_drop_reg;
    logic l1_reg;

    // Power state machine of this bridge
    bridge_pm_fsm u_fsm (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .pm_control_status_reg_wr(pm_control_status_reg_wr[g]),
      .configured(configured[g]),
      .power_removed(power_removed),
      .state(port_state[g]),
      .power_state_field(power_state_field[g]),
      .context_kept_flag(context_kept_flag[g])
    );

    // Traffic verdict, one cycle after the transaction is presented
    always_ff @(posedge clk_sys or negedge rstn)
      if (!rstn)
        verdict_reg <= '{valid: 1'b0, decision: DEC_NONE};
      else if (tlp_in[g].valid && port_state[g] != PM_D3_COLD)
        verdict_reg <= '{valid: 1'b1, decision: classify(port_state[g], tlp_in[g])};
      else
        verdict_reg <= '{valid: 1'b0, decision: DEC_NONE};

    // Error reporting; TLP-caused errors win when both arrive together
    always_ff @(posedge clk_sys or negedge rstn)
      if (!rstn)
      begin
        err_send_reg <= 1'b0;
        err_drop_reg <= 1'b0;
      end
      else
      begin
        err_send_reg <= err_tlp_evt[g] || (err_other_evt[g] && port_state[g] != PM_D3_HOT);
        err_drop_reg <= !err_tlp_evt[g] && err_other_evt[g] && port_state[g] == PM_D3_HOT;
      end

    // Link may enter L1 while its bridge sits in D3hot
    always_ff @(posedge clk_sys or negedge rstn)
      if (!rstn) l1_reg <= 1'b0;
      else l1_reg <= (port_state[g] == PM_D3_HOT);

    assign verdict[g] = verdict_reg;
    assign err_msg_send[g] = err_send_reg;
    assign err_msg_drop[g] = err_drop_reg;
    assign l1_allowed[g] = l1_reg;

    property p_d3_cfg0;
      @(posedge clk_sys) disable iff (!rstn)
      port_state[g] == PM_D3_HOT && tlp_in[g].valid && !tlp_in[g].from_secondary && tlp_in[g].kind == TLP_CFG0
        |=> verdict_reg.valid && verdict_reg.decision == DEC_ACCEPT;
    endproperty
    a_d3_cfg0: assert property (p_d3_cfg0) else $error("Type 0 config not accepted in D3hot");

    property p_d3_msg;
      @(posedge clk_sys) disable iff (!rstn)
      port_state[g] == PM_D3_HOT && tlp_in[g].valid && !tlp_in[g].from_secondary
        && tlp_in[g].kind == TLP_MSG && tlp_in[g].to_bridge
        |=> verdict_reg.valid && verdict_reg.decision == DEC_ACCEPT;
    endproperty
    a_d3_msg: assert property (p_d3_msg) else $error("Bridge message not accepted in D3hot");

    property p_d3_prim_ur;
      @(posedge clk_sys) disable iff (!rstn)
      port_state[g] == PM_D3_HOT && tlp_in[g].valid && !tlp_in[g].from_secondary
        && (tlp_in[g].kind == TLP_CFG1 || tlp_in[g].kind == TLP_MEM_IO
        || (tlp_in[g].kind == TLP_MSG && !tlp_in[g].to_bridge))
        |=> verdict_reg.decision == DEC_UR;
    endproperty
    a_d3_prim_ur: assert property (p_d3_prim_ur) else $error("Primary request not UR in D3hot");

    property p_err_tlp;
      @(posedge clk_sys) disable iff (!rstn)
      err_tlp_evt[g] |=> err_send_reg && !err_drop_reg;
    endproperty
    a_err_tlp: assert property (p_err_tlp) else $error("TLP error not reported");

    property p_err_other;
      @(posedge clk_sys) disable iff (!rstn)
      port_state[g] == PM_D3_HOT && err_other_evt[g] && !err_tlp_evt[g]
        |=> !err_send_reg && err_drop_reg;
    endproperty
    a_err_other: assert property (p_err_other) else $error("Non-TLP error sent in D3hot");

    property p_d3_uc;
      @(posedge clk_sys) disable iff (!rstn)
      port_state[g] == PM_D3_HOT && tlp_in[g].valid && tlp_in[g].kind == TLP_CPL && tlp_in[g].to_bridge
        |=> verdict_reg.decision == DEC_UC;
    endproperty
    a_d3_uc: assert property (p_d3_uc) else $error("Own completion not UC in D3hot");

    property p_d3_route;
      @(posedge clk_sys) disable iff (!rstn)
      port_state[g] == PM_D3_HOT && tlp_in[g].valid && tlp_in[g].kind == TLP_CPL && !tlp_in[g].to_bridge
        |=> verdict_reg.valid && verdict_reg.decision == DEC_ROUTE;
    endproperty
    a_d3_route: assert property (p_d3_route) else $error("Passing completion not routed");

    property p_d3_sec_ur;
      @(posedge clk_sys) disable iff (!rstn)
      port_state[g] == PM_D3_HOT && tlp_in[g].valid && tlp_in[g].from_secondary && tlp_in[g].kind != TLP_CPL
        |=> verdict_reg.decision == DEC_UR;
    endproperty
    a_d3_sec_ur: assert property (p_d3_sec_ur) else $error("Secondary request not UR in D3hot");

    property p_l1;
      @(posedge clk_sys) disable iff (!rstn)
      port_state[g] == PM_D3_HOT ##1 port_state[g] == PM_D3_HOT |-> l1_reg;
    endproperty
    a_l1: assert property (p_l1) else $error("L1 not allowed in D3hot");

    property p_reset_state;
      @(posedge clk_sys)
      !rstn |-> port_state[g] == PM_D0_UNINIT && !l1_reg;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("Reset did not give D0 uninit");

    c_d3_entry: cover property (@(posedge clk_sys) disable iff (!rstn)
      port_state[g] == PM_D0_ACTIVE ##1 port_state[g] == PM_D3_HOT);
    c_d3_ur: cover property (@(posedge clk_sys) disable iff (!rstn)
      verdict_reg.valid && verdict_reg.decision == DEC_UR);
    c_resume: cover property (@(posedge clk_sys) disable iff (!rstn)
      port_state[g] == PM_D3_HOT ##1 port_state[g] == PM_D0_UNINIT);
  end

  // Turn-off broadcast and acknowledge collection
  pme_fence #(
    .NUM_PORTS(NUM_PORTS)
  ) u_fence (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .turn_off_rx(pme_turn_off_rx),
    .link_active(link_active),
    .ack_rx(pme_to_ack_rx),
    .resume(port_state[UPSTREAM_PORT] == PM_D0_UNINIT),
    .turn_off_fwd(pme_turn_off_fwd),
    .ack_tx(pme_to_ack_tx),
    .done(fence_done)
  );

  // Whole device goes low only when the upstream bridge is low and the fence closed
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      upstream_low_reg <= 1'b0;
      device_low_reg <= 1'b0;
      l2l3_reg <= 1'b0;
    end
    else
    begin
      upstream_low_reg <= port_state[UPSTREAM_PORT] == PM_D3_HOT || port_state[UPSTREAM_PORT] == PM_D3_COLD;
      device_low_reg <= upstream_low_reg && fence_done;
      l2l3_reg <= fence_done;
    end

  assign device_low_power = device_low_reg;
  assign l2l3_ready = l2l3_reg;

  property p_device_low;
    @(posedge clk_sys) disable iff (!rstn)
    device_low_reg |-> $past(upstream_low_reg) && $past(fence_done);
  endproperty
  a_device_low: assert property (p_device_low) else $error("Device low without upstream low and acks");

  property p_device_low_set;
    @(posedge clk_sys) disable iff (!rstn)
    port_state[UPSTREAM_PORT] == PM_D3_HOT && fence_done ##1 port_state[UPSTREAM_PORT] == PM_D3_HOT && fence_done
      |=> device_low_reg;
  endproperty
  a_device_low_set: assert property (p_device_low_set) else $error("Device did not enter low power");

  property p_fwd_active;
    @(posedge clk_sys) disable iff (!rstn)
    pme_turn_off_fwd != '0 |-> (pme_turn_off_fwd & ~$past(link_active)) == '0 && !pme_turn_off_fwd[UPSTREAM_PORT];
  endproperty
  a_fwd_active: assert property (p_fwd_active) else $error("Turn-off sent to inactive port");

  c_fence_done: cover property (@(posedge clk_sys) disable iff (!rstn)
    pme_turn_off_fwd != '0 ##[1:50] pme_to_ack_tx);

endmodule : pcie_bridge_power_state_control

// ==== ack_model.sv ====
`timescale 1ns/1ns
// Downstream ends answering a forwarded turn-off after a per-port delay
module ack_model #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Turn-off in, acknowledges out
  input wire logic [N-1:0] turn_off_fwd,
  input wire logic slow,
  output logic [N-1:0] ack
);
  logic [7:0] cnt_reg [N];

  // One ack per forwarded port, never before the forward; slow mode spreads them out
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (!rstn)
      begin
        cnt_reg[i] <= 8'h00;
        ack[i] <= 1'b0;
      end
      else
      begin
        ack[i] <= (cnt_reg[i] == 8'h01);
        if (turn_off_fwd[i])
          cnt_reg[i] <= slow ? 8'(4 + 3 * i) : 8'(1 + i);
        else if (cnt_reg[i] != 8'h00)
          cnt_reg[i] <= cnt_reg[i] - 8'h01;
      end
    end
  end
endmodule : ack_model

// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
  import pm_ctrl_pkg::*;
  localparam int NP = 4;
  logic clk_sys, rstn, power_removed, pme_turn_off_rx, slow;
  logic pme_to_ack_tx, l2l3_ready, device_low_power;
  logic [NP-1:0] configured, link_active, pme_to_ack_rx, err_tlp_evt, err_other_evt, acked;
  logic [NP-1:0] context_kept_flag, l1_allowed, err_msg_send, err_msg_drop, pme_turn_off_fwd;
  pm_control_status_reg_write_type pm_control_status_reg_wr [NP];
  tlp_info_type tlp_in [NP];
  pm_state_type port_state [NP];
  logic [1:0] power_state_field [NP];
  tlp_verdict_type verdict [NP];
  int errors, cmp_count, cycles;

  pcie_bridge_power_state_control #(.NUM_PORTS(NP)) i_dut (
    .clk_sys, .rstn, .pm_control_status_reg_wr, .configured, .power_removed, .tlp_in,
    .err_tlp_evt, .err_other_evt, .pme_turn_off_rx, .link_active, .pme_to_ack_rx,
    .port_state, .power_state_field, .context_kept_flag, .l1_allowed, .verdict,
    .err_msg_send, .err_msg_drop, .pme_turn_off_fwd, .pme_to_ack_tx, .l2l3_ready,
    .device_low_power
  );

  ack_model #(.N(NP)) i_ack (
    .clk_sys, .rstn, .turn_off_fwd(pme_turn_off_fwd), .slow, .ack(pme_to_ack_rx)
  );

  // Free-running system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Hang guard and collection of acks seen since the last turn-off
  always @(posedge clk_sys)
  begin
    cycles++;
    acked <= pme_turn_off_rx ? '0 : (acked | pme_to_ack_rx);
    if (cycles == 3000)
    begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_st(input pm_state_type got, input pm_state_type exp);
    chk(32'(got), 32'(exp));
  endtask : chk_st

  task automatic chk_vd(input tlp_verdict_type got, input tlp_verdict_type exp);
    chk(32'(got), 32'(exp));
  endtask : chk_vd

  // Expected verdict; in D3hot, secondary-side requests are refused before the primary split
  function automatic tlp_decision_type exp_dec(input logic hot, input tlp_info_type t);
    logic own;
    own = t.to_bridge && (t.kind == TLP_MSG || t.kind == TLP_CPL);
    if (!hot)
      return (t.kind == TLP_CFG0 || own) ? DEC_ACCEPT : DEC_ROUTE;
    if (t.kind == TLP_CPL)
      return t.to_bridge ? DEC_UC : DEC_ROUTE;
    if (t.from_secondary)
      return DEC_UR;
    return (t.kind == TLP_CFG0 || own) ? DEC_ACCEPT : DEC_UR;
  endfunction : exp_dec

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
  endtask : do_reset

  task automatic wr(input int p, input logic [1:0] c);
    @(posedge clk_sys) pm_control_status_reg_wr[p] <= '{1'b1, c};
    @(posedge clk_sys) pm_control_status_reg_wr[p] <= '0;
    @(negedge clk_sys);
  endtask : wr

  // Turn-off with a random active mask; the upstream ack must wait for every forwarded port
  task automatic fence(input logic s);
    logic [NP-1:0] m;
    int n;
    m = (NP'($urandom) & 4'hE) | 4'h2;
    @(posedge clk_sys);
    slow <= s;
    link_active <= m;
    pme_turn_off_rx <= 1'b1;
    @(posedge clk_sys) pme_turn_off_rx <= 1'b0;
    @(negedge clk_sys);
    chk(32'(pme_turn_off_fwd), 32'(m));
    n = 0;
    while (pme_to_ack_tx !== 1'b1 && n < 40)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(32'(acked), 32'(m));
    @(negedge clk_sys);
    chk(32'(l2l3_ready), 32'h1);
  endtask : fence

  // Main sequence
  initial
  begin
    tlp_info_type a, b, pa, pb;
    int n;
    rstn = 1'b0;
    {configured, power_removed, err_tlp_evt, err_other_evt} = '0;
    {pme_turn_off_rx, link_active, slow} = '0;
    foreach (tlp_in[p])
    begin
      tlp_in[p] = '0;
      pm_control_status_reg_wr[p] = '0;
    end
    void'($urandom(32'hC57C9CEB));
    do_reset();
    for (int p = 0; p < NP; p++)
    begin
      chk_st(port_state[p], PM_D0_UNINIT);
      chk(32'(power_state_field[p]), 32'(PS_FIELD_RST));
    end
    chk(32'(context_kept_flag), 32'hF);
    @(posedge clk_sys) configured <= '1;
    @(posedge clk_sys) configured <= '0;
    @(negedge clk_sys);
    for (int p = 0; p < NP; p++)
      chk_st(port_state[p], PM_D0_ACTIVE);
    // Reserved codes and the D0 code are refused while active
    wr(1, 2'h1);
    wr(1, 2'h2);
    wr(1, PS_CODE_D0);
    chk_st(port_state[1], PM_D0_ACTIVE);
    wr(1, PS_CODE_D3HOT);
    chk_st(port_state[1], PM_D3_HOT);
    chk(32'(power_state_field[1]), 32'h3);
    chk_st(port_state[2], PM_D0_ACTIVE);
    @(negedge clk_sys);
    chk(32'(l1_allowed), 32'h2);
    // Back-to-back traffic: every kind in D3hot on port 1, random traffic in D0 on port 2
    for (int i = 0; i <= 40; i++)
    begin
      a = '{i < 40, i[0], i[1], tlp_kind_type'((i >> 2) % 5)};
      b = '{i < 40, 1'($urandom), 1'($urandom), tlp_kind_type'($urandom % 5)};
      @(posedge clk_sys);
      tlp_in[1] <= a;
      tlp_in[2] <= b;
      @(negedge clk_sys);
      if (i > 0)
      begin
        chk_vd(verdict[1], '{1'b1, exp_dec(1'b1, pa)});
        chk_vd(verdict[2], '{1'b1, exp_dec(1'b0, pb)});
      end
      pa = a;
      pb = b;
    end
    @(negedge clk_sys);
    chk(32'(verdict[1].valid), 32'h0);
    // Error causes in D3hot and in D0
    @(posedge clk_sys);
    err_tlp_evt <= 4'h2;
    err_other_evt <= 4'h4;
    @(posedge clk_sys);
    err_tlp_evt <= 4'h0;
    err_other_evt <= 4'h2;
    @(negedge clk_sys);
    chk(32'(err_msg_send), 32'h6);
    @(posedge clk_sys) err_other_evt <= 4'h0;
    @(negedge clk_sys);
    chk(32'(err_msg_send), 32'h0);
    chk(32'(err_msg_drop), 32'h2);
    wr(1, PS_CODE_D0);
    chk_st(port_state[1], PM_D0_UNINIT);
    chk(32'(power_state_field[1]), 32'h0);
    chk(32'(context_kept_flag), 32'hF);
    // Fence, then the upstream port decides whole-device low power
    fence(1'b1);
    chk(32'(device_low_power), 32'h0);
    wr(0, PS_CODE_D3HOT);
    n = 0;
    while (device_low_power !== 1'b1 && n < 6)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(32'(device_low_power), 32'h1);
    wr(0, PS_CODE_D0);
    wr(0, PS_CODE_D3HOT);
    chk_st(port_state[0], PM_D0_UNINIT);
    repeat (3) @(negedge clk_sys);
    chk(32'(l2l3_ready), 32'h0);
    fence(1'b0);
    // Power removal takes a D3hot bridge to D3cold, which then ignores traffic
    wr(3, PS_CODE_D3HOT);
    @(posedge clk_sys) power_removed <= 1'b1;
    @(posedge clk_sys) power_removed <= 1'b0;
    @(negedge clk_sys);
    chk_st(port_state[3], PM_D3_COLD);
    chk_st(port_state[2], PM_D0_ACTIVE);
    @(posedge clk_sys) tlp_in[3] <= '{1'b1, 1'b0, 1'b0, TLP_CFG0};
    @(posedge clk_sys) tlp_in[3] <= '0;
    @(negedge clk_sys);
    chk(32'(verdict[3].valid), 32'h0);
    do_reset();
    chk_st(port_state[3], PM_D0_UNINIT);
    test_done();
  end
endmodule : tb
